// [hw/mspcs_pkg.sv]
// package for the host serial pcs status register bank
// assumes a plain address/strobe register port and 16-bit registers
package mspcs_pkg;
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 16;

    // register offsets in the extended page
    localparam logic [4:0] OFF_PCS_CTRL    = 5'h10;
    localparam logic [4:0] OFF_PCS_STATUS  = 5'h11;
    localparam logic [4:0] OFF_ADV_WORD    = 5'h12;
    localparam logic [4:0] OFF_LP_WORD     = 5'h13;
    localparam logic [4:0] OFF_SER_STATUS  = 5'h14;
    localparam logic [4:0] OFF_TX_GOOD     = 5'h15;
    localparam logic [4:0] OFF_CNT_SEL     = 5'h16;

    // field positions
    localparam int unsigned BIT_SYNC_FAIL  = 15;
    localparam int unsigned BIT_CG_BAD     = 14;
    localparam int unsigned BIT_ALIGN_ERR  = 12;
    localparam int unsigned BIT_LP_RESTART = 11;
    localparam int unsigned BIT_RF_LO      = 8;
    localparam int unsigned BIT_ABIL_LO    = 4;
    localparam int unsigned BIT_LP_AN_CAP  = 3;
    localparam int unsigned BIT_LINK       = 2;
    localparam int unsigned BIT_AN_DONE    = 1;
    localparam int unsigned BIT_SIG_DET    = 0;
    localparam int unsigned BIT_REALIGN    = 15;
    localparam int unsigned BIT_SER_SD     = 14;
    localparam int unsigned BIT_QSYNC      = 13;
    localparam int unsigned BIT_COMMA      = 12;
    localparam int unsigned BIT_CPOS_LO    = 8;
    localparam int unsigned BIT_CNT_ACT    = 15;
    localparam int unsigned BIT_FORCE_ADV  = 11;
    localparam int unsigned BIT_SEL_LO     = 14;
    localparam int unsigned BIT_CNT_LO     = 0;

    // partner code word bit positions used by the decoded status fields
    localparam int unsigned LPW_RF_LO      = 12;
    localparam int unsigned LPW_ASYM       = 8;
    localparam int unsigned LPW_SYM        = 7;
    localparam int unsigned LPW_HD         = 6;
    localparam int unsigned LPW_FD         = 5;

    // reset values and counts
    localparam logic [15:0] ADV_RESET      = 16'h0000;
    localparam logic [13:0] CNT_WRAP       = 14'h270f;  // 9999, modulo 10000
    localparam logic [3:0]  CPOS_MAX       = 4'h9;
    localparam logic [1:0]  SEL_MEDIA      = 2'h0;
    localparam logic [1:0]  SEL_HOST       = 2'h1;

    // events and levels from the serial pcs datapath
    typedef struct packed {
        logic       sync_lost;     // pulse
        logic       cg_bad;        // pulse
        logic       align_err;     // pulse
        logic       lp_restart;    // pulse
        logic       realign;       // pulse
        logic       sig_det_evt;   // pulse
        logic       lp_word_vld;   // pulse with lp_word
        logic [15:0] lp_word;
        logic       lp_an_cap;     // level
        logic       link_up;       // level
        logic       an_done;       // level
        logic       sig_det;       // level
        logic       qsgmii_sync;   // level
        logic       comma_det;     // level
        logic [3:0] comma_pos;     // level
        logic       media_tx_good; // pulse
        logic       host_tx_good;  // pulse
        logic       media_link_up; // level
    } mspcs_stat_t;
endpackage

// [hw/mspcs_regs.sv]
// host serial pcs status/ability register bank with tx good packet counter
// assumes pcs inputs come from the same clock domain; register port is
// address/strobe with read data one cycle after the read strobe
//
// How it works
// RL1 - bit 15 latches sync loss until the status register is next read
// RL2 - bit 14 latches invalid code-group until next status read
// RL3 - bit 12 shows an sgmii alignment error occurred
// RL4 - bit 11 shows the partner requested autonegotiation restart
// RL5 - bits 9:8 hold partner remote fault, nonzero means fault
// RL6 - bits 7:4 show partner asym pause, sym pause, full, half duplex
// RL7 - bit 3 shows partner is autonegotiation capable
// RL8 - bit 2 link connected, bit 1 autonegotiation complete
// RL9 - bit 0 shows pcs signal detect present
// RL10 - advertised word resets to zero, writable only with force bit set
// RL11 - advertised readback undefined when force bit clear; software ignores it
// RL12 - last partner config word captured in a read-only register
// RL13 - serial status bit 15 sticky on comma realignment, clears on read
// RL14 - serial status bit 14 sticky on signal detection, clears on read
// RL15 - bit 13 gives qsgmii sync, meaningful only on first port
// RL16 - bit 12 latches low on comma detect loss, set to one after each read
// RL17 - bits 11:8 give comma position 0 to 9
// RL18 - counter register bit 15 shows counter active
// RL19 - 14-bit good packet count wraps modulo ten thousand
// RL20 - counters run only while media link is up
// RL21 - two-bit select chooses media or host side counters
// RL22 - software selects page three before access; outside this block
// RL23 - reserved bits read zero, writes to read-only fields ignored
// RL24 - since-last-read bits clear on read unless condition persists
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps

module mspcs_regs
    import mspcs_pkg::*;
(
    input  wire logic                      REF_CLK,
    input  wire logic                      NRST,
    input  wire logic [mspcs_pkg::ADDR_W-1:0] ADDR,
    input  wire logic [mspcs_pkg::DATA_W-1:0] WDATA,
    input  wire logic                      WR,
    input  wire logic                      RD,
    output logic      [mspcs_pkg::DATA_W-1:0] RDATA,
    input  wire mspcs_pkg::mspcs_stat_t    PCS_STAT,
    input  wire logic                      FIRST_PORT,
    output logic      [mspcs_pkg::DATA_W-1:0] ADV_WORD,
    output logic                           FORCE_ADV
);
    import mspcs_pkg::*;

    // address match, shared by the read strobe decodes and the write decodes
    function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
        return a == off;
    endfunction

    logic        rd_pcs;
    logic        rd_ser;
    logic        sync_fail_reg;
    logic        cg_bad_reg;
    logic        align_err_reg;
    logic        lp_restart_reg;
    logic        realign_reg;
    logic        ser_sd_reg;
    logic        comma_reg;
    logic        force_reg;
    logic [15:0] adv_reg;
    logic [15:0] lp_reg;
    logic [1:0]  sel_reg;
    logic [13:0] cnt_reg;
    logic        cnt_evt;
    logic [15:0] rdata_next;
    logic [15:0] rdata_reg;

    assign rd_pcs = RD && hit(ADDR, OFF_PCS_STATUS);
    assign rd_ser = RD && hit(ADDR, OFF_SER_STATUS);

    // latched status flags: a new event in the read cycle wins over the clear
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            sync_fail_reg  <= 1'b0;
            cg_bad_reg     <= 1'b0;
            align_err_reg  <= 1'b0;
            lp_restart_reg <= 1'b0;
        end else begin
            sync_fail_reg  <= PCS_STAT.sync_lost  | (sync_fail_reg  & ~rd_pcs); // RL1 RL24
            cg_bad_reg     <= PCS_STAT.cg_bad     | (cg_bad_reg     & ~rd_pcs); // RL2 RL24
            align_err_reg  <= PCS_STAT.align_err  | (align_err_reg  & ~rd_pcs); // RL3
            lp_restart_reg <= PCS_STAT.lp_restart | (lp_restart_reg & ~rd_pcs); // RL4
        end
    end

    // serial status sticky bits
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            realign_reg <= 1'b0;
            ser_sd_reg  <= 1'b0;
            comma_reg   <= 1'b1;
        end else begin
            realign_reg <= PCS_STAT.realign     | (realign_reg & ~rd_ser); // RL13
            ser_sd_reg  <= PCS_STAT.sig_det_evt | (ser_sd_reg  & ~rd_ser); // RL14
            // comma flag: reread sets to one, otherwise tracks detector loss
            if (rd_ser) begin
                comma_reg <= 1'b1; // RL16
            end else if (!PCS_STAT.comma_det) begin
                comma_reg <= 1'b0; // RL16
            end
        end
    end

    // control: force bit and counter select, software owned
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            force_reg <= 1'b0;
            sel_reg   <= SEL_MEDIA;
        end else if (WR) begin
            if (hit(ADDR, OFF_PCS_CTRL)) begin
                force_reg <= WDATA[BIT_FORCE_ADV];
            end
            if (hit(ADDR, OFF_CNT_SEL)) begin
                sel_reg <= WDATA[BIT_SEL_LO +: 2]; // RL21
            end
        end
    end

    // advertised word, writes gated by the force bit
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            adv_reg <= ADV_RESET; // RL10
        end else if (WR && hit(ADDR, OFF_ADV_WORD) && force_reg) begin
            adv_reg <= WDATA; // RL10
        end
    end

    // partner code word capture
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            lp_reg <= 16'h0000;
        end else if (PCS_STAT.lp_word_vld) begin
            lp_reg <= PCS_STAT.lp_word; // RL12
        end
    end

    // good packet counter, selected side, runs only with media link up
    assign cnt_evt = PCS_STAT.media_link_up &&                              // RL20
        ((sel_reg == SEL_MEDIA && PCS_STAT.media_tx_good) ||
         (sel_reg == SEL_HOST  && PCS_STAT.host_tx_good));                 // RL21

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            cnt_reg <= 14'h0000;
        end else if (cnt_evt) begin
            cnt_reg <= (cnt_reg == CNT_WRAP) ? 14'h0000 : cnt_reg + 14'h0001; // RL19
        end
    end

    // read mux; reserved bits and unmapped offsets read zero
    always_comb begin
        rdata_next = 16'h0000; // RL23
        if (RD) begin
            case (ADDR)
                OFF_PCS_CTRL: begin
                    rdata_next[BIT_FORCE_ADV] = force_reg;
                end
                OFF_PCS_STATUS: begin
                    rdata_next[BIT_SYNC_FAIL]  = sync_fail_reg;           // RL1
                    rdata_next[BIT_CG_BAD]     = cg_bad_reg;              // RL2
                    rdata_next[BIT_ALIGN_ERR]  = align_err_reg;           // RL3
                    rdata_next[BIT_LP_RESTART] = lp_restart_reg;          // RL4
                    rdata_next[BIT_RF_LO +: 2] = lp_reg[LPW_RF_LO +: 2];  // RL5
                    rdata_next[BIT_ABIL_LO+3]  = lp_reg[LPW_ASYM];        // RL6
                    rdata_next[BIT_ABIL_LO+2]  = lp_reg[LPW_SYM];         // RL6
                    rdata_next[BIT_ABIL_LO+1]  = lp_reg[LPW_FD];          // RL6
                    rdata_next[BIT_ABIL_LO]    = lp_reg[LPW_HD];          // RL6
                    rdata_next[BIT_LP_AN_CAP]  = PCS_STAT.lp_an_cap;      // RL7
                    rdata_next[BIT_LINK]       = PCS_STAT.link_up;        // RL8
                    rdata_next[BIT_AN_DONE]    = PCS_STAT.an_done;        // RL8
                    rdata_next[BIT_SIG_DET]    = PCS_STAT.sig_det;        // RL9
                end
                OFF_ADV_WORD: begin
                    rdata_next = adv_reg; // RL11
                end
                OFF_LP_WORD: begin
                    rdata_next = lp_reg;
                end
                OFF_SER_STATUS: begin
                    rdata_next[BIT_REALIGN] = realign_reg;
                    rdata_next[BIT_SER_SD]  = ser_sd_reg;
                    rdata_next[BIT_QSYNC]   = FIRST_PORT & PCS_STAT.qsgmii_sync; // RL15
                    rdata_next[BIT_COMMA]   = comma_reg;
                    // clamp out-of-range positions to the last legal one
                    rdata_next[BIT_CPOS_LO +: 4] = (PCS_STAT.comma_pos > CPOS_MAX) ?
                        CPOS_MAX : PCS_STAT.comma_pos; // RL17
                end
                OFF_TX_GOOD: begin
                    rdata_next[BIT_CNT_ACT] = PCS_STAT.media_link_up; // RL18
                    rdata_next[BIT_CNT_LO +: 14] = cnt_reg;           // RL19
                end
                OFF_CNT_SEL: begin
                    rdata_next[BIT_SEL_LO +: 2] = sel_reg;
                end
                default: begin
                    rdata_next = 16'h0000;
                end
            endcase
        end
    end

    // read data registered, valid the cycle after the strobe only
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            rdata_reg <= 16'h0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign RDATA     = rdata_reg;
    assign ADV_WORD  = adv_reg;
    assign FORCE_ADV = force_reg;
endmodule // mspcs_regs

// [tb/mspcs_chk.sv]
// port checker for the pcs status register bank
// assumes it is bound onto mspcs_regs, one clock domain
`timescale 1ns/1ps
module mspcs_chk
    import mspcs_pkg::*;
(
    input wire logic                  REF_CLK,
    input wire logic                  NRST,
    input wire logic [4:0]            ADDR,
    input wire logic [15:0]           WDATA,
    input wire logic                  WR,
    input wire logic                  RD,
    input wire logic [15:0]           RDATA,
    input wire mspcs_pkg::mspcs_stat_t PCS_STAT,
    input wire logic                  FIRST_PORT,
    input wire logic [15:0]           ADV_WORD,
    input wire logic                  FORCE_ADV
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    // read decodes; a gap cycle keeps a prior read from clearing flags
    wire rd_st  = RD && ADDR == OFF_PCS_STATUS;
    wire rd_ser = RD && ADDR == OFF_SER_STATUS;
    wire rd_cnt = RD && ADDR == OFF_TX_GOOD;
    rd_idle_a: assert property (!$past(RD) |-> RDATA == 16'h0000)
        else $error("read data not zero outside a read");
    sync_flag_a: assert property (
        rd_st && !$past(rd_st) && $past(PCS_STAT.sync_lost, 2) |=> RDATA[15])
        else $error("sync loss flag missing");
    live_bits_a: assert property (
        rd_st |=> RDATA[3:0] == $past({PCS_STAT.lp_an_cap,
        PCS_STAT.link_up, PCS_STAT.an_done, PCS_STAT.sig_det}))
        else $error("live status bits wrong");
    adv_lock_a: assert property (
        WR && ADDR == OFF_ADV_WORD && !FORCE_ADV |=> $stable(ADV_WORD))
        else $error("advertised word changed without force");
    adv_write_a: assert property (
        WR && ADDR == OFF_ADV_WORD && FORCE_ADV |=> ADV_WORD == $past(WDATA))
        else $error("advertised word not written");
    ser_bits_a: assert property (
        rd_ser |=> RDATA[13] == $past(FIRST_PORT && PCS_STAT.qsgmii_sync)
        && RDATA[7:0] == 8'h00)
        else $error("serial sync or reserved bits wrong");
    comma_pos_a: assert property (
        rd_ser |=> RDATA[11:8] == ($past(PCS_STAT.comma_pos) > 4'h9
        ? 4'h9 : $past(PCS_STAT.comma_pos)))
        else $error("comma position wrong");
    cnt_active_a: assert property (
        rd_cnt |=> RDATA[15:14] == {$past(PCS_STAT.media_link_up), 1'b0})
        else $error("counter active bit wrong");
    realign_flag_a: assert property (
        rd_ser && !$past(rd_ser) && $past(PCS_STAT.realign, 2) |=> RDATA[15])
        else $error("realign flag missing");
    cover property (rd_st ##1 RDATA[15]);
    cover property (WR && FORCE_ADV && ADDR == OFF_ADV_WORD);
    cover property (rd_cnt ##1 RDATA[15]);
endmodule // mspcs_chk
bind mspcs_regs mspcs_chk u_chk (.REF_CLK(REF_CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .PCS_STAT(PCS_STAT), .FIRST_PORT(FIRST_PORT),
    .ADV_WORD(ADV_WORD), .FORCE_ADV(FORCE_ADV));

// [tb/mspcs_mac_model.sv]
// mac side model: one good packet strobe per cycle that go is high
// assumes the bench times go on the rising edge
`timescale 1ns/1ps
module mspcs_mac_model (
    input  wire logic REF_CLK,
    input  wire logic NRST,
    input  wire logic go,
    output logic      tx_good
);
    // registered, so a strobe lands one cycle after the request
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST)
            tx_good <= 1'b0;
        else
            tx_good <= go;
    end
endmodule // mspcs_mac_model

// [tb/tb_top.sv]
// self-checking bench for the pcs status register bank
// assumes a 200 MHz clock and the mac model on the host tx strobe
`timescale 1ns/1ps
module tb_top;
    import mspcs_pkg::*;
    logic        clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, fp = 1'b1, go = 1'b0;
    logic [4:0]  addr = 5'h00;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata, adv;
    logic        fadv, txg;
    mspcs_stat_t stat = '0;
    mspcs_stat_t pcs;
    int          err_count = 0;
    int          n_checks = 0;
    always #2.5 clk = ~clk;
    // mac model strobe merged into the datapath status as host tx good
    always_comb begin
        pcs = stat;
        pcs.host_tx_good = txg;
    end
    mspcs_mac_model u_mac (.REF_CLK(clk), .NRST(nrst), .go(go), .tx_good(txg));
    mspcs_regs DUT (.REF_CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .PCS_STAT(pcs), .FIRST_PORT(fp), .ADV_WORD(adv), .FORCE_ADV(fadv));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // offsets assume software already selected page three
    task automatic wrr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task automatic t_status;
        @(posedge clk);
        {stat.sync_lost, stat.cg_bad, stat.align_err, stat.lp_restart} <= 4'hf;
        stat.lp_word <= 16'h21a0;
        stat.lp_word_vld <= 1'b1;
        @(posedge clk);
        {stat.sync_lost, stat.cg_bad, stat.align_err, stat.lp_restart, stat.lp_word_vld} <= 5'h00;
        rdc(OFF_PCS_STATUS, 16'hdaed);
        rdc(OFF_PCS_STATUS, 16'h02ed);
        rdc(OFF_LP_WORD, 16'h21a0);
    endtask
    task automatic t_serial;
        @(posedge clk);
        {stat.realign, stat.sig_det_evt} <= 2'h3;
        @(posedge clk);
        {stat.realign, stat.sig_det_evt} <= 2'h0;
        rdc(OFF_SER_STATUS, 16'hf900);
        @(posedge clk);
        fp <= 1'b0;
        rdc(OFF_SER_STATUS, 16'h1900);
        @(posedge clk);
        stat.comma_det <= 1'b0;
        @(posedge clk);
        stat.comma_det <= 1'b1;
        rdc(OFF_SER_STATUS, 16'h0900);
        rdc(OFF_SER_STATUS, 16'h1900);
    endtask
    task automatic t_adv;
        wrr(OFF_ADV_WORD, 16'hbeef);
        rdc(OFF_ADV_WORD, ADV_RESET);
        wrr(OFF_PCS_CTRL, 16'h0800);
        wrr(OFF_ADV_WORD, 16'hbeef);
        rdc(OFF_ADV_WORD, 16'hbeef);
        chk(adv, 16'hbeef);
        chk({15'h0000, fadv}, 16'h0001);
        rdc(OFF_PCS_CTRL, 16'h0800);
        wrr(OFF_LP_WORD, 16'hffff);
        rdc(OFF_LP_WORD, 16'h21a0);
        rdc(5'h1f, 16'h0000);
    endtask
    // long burst crosses the modulo wrap, then link down must freeze the count
    task automatic t_cnt;
        wrr(OFF_CNT_SEL, 16'h4000);
        rdc(OFF_CNT_SEL, 16'h4000);
        @(posedge clk);
        stat.media_link_up <= 1'b1;
        go <= 1'b1;
        repeat (10003) @(posedge clk);
        go <= 1'b0;
        rdc(OFF_TX_GOOD, 16'h8003);
        @(posedge clk);
        stat.media_link_up <= 1'b0;
        go <= 1'b1;
        repeat (4) @(posedge clk);
        go <= 1'b0;
        repeat (2) @(posedge clk);
        rdc(OFF_TX_GOOD, 16'h0003);
        // media side selected: only media strobes count, host strobes ignored
        wrr(OFF_CNT_SEL, 16'h0000);
        @(posedge clk);
        stat.media_link_up <= 1'b1;
        stat.media_tx_good <= 1'b1;
        go <= 1'b1;
        @(posedge clk);
        stat.media_tx_good <= 1'b0;
        go <= 1'b0;
        repeat (2) @(posedge clk);
        rdc(OFF_TX_GOOD, 16'h8004);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        stat.comma_pos = 4'hc;
        {stat.lp_an_cap, stat.link_up, stat.sig_det, stat.comma_det, stat.qsgmii_sync} = 5'h1f;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        t_status();
        t_serial();
        t_adv();
        t_cnt();
        print_verdict();
    end
endmodule // tb_top
